// ### logic/iemr_pkg.sv
// package: constants for the interrupt enable mask register block
// assumes a 40 MHz system clock and an APB master with 32-bit data
//
// Behaviour
// - global bit 7 zero blocks every source
// - bit 5 gates timer2 low/high overflow
// - bit 4 gates the uart request
// - bit 2 gates external pin 1 requests
// - bit 1 gates timer0 overflow requests
// - register at A8, single bits settable
package iemr_pkg;
	localparam int IEMR_ADDR_W = 12;
	// printed offset A8 is a multiple of four: byte address as printed
	localparam logic [11:0] IEMR_MASK_OFFSET = 12'h0A8;
	// bit-operation port: wdata[2:0] selects bit, wdata[8] is the value
	localparam logic [11:0] IEMR_BITOP_OFFSET = 12'h0AC;
	localparam logic [11:0] IEMR_STATUS_OFFSET = 12'h0B0;
	localparam int IEMR_BITOP_VAL_POS = 8;
	localparam int IEMR_GLOBAL_POS = 7;
	localparam int IEMR_SPARE_POS = 6;
	localparam int IEMR_T2_POS = 5;
	localparam int IEMR_UART_POS = 4;
	localparam int IEMR_T1_POS = 3;
	localparam int IEMR_X1_POS = 2;
	localparam int IEMR_T0_POS = 1;
	localparam int IEMR_X0_POS = 0;
	localparam logic [7:0] IEMR_MASK_RESET = 8'h00;
	localparam int IEMR_SRC_N = 6;
endpackage

// ### logic/iemr_gate_if.sv
// interface: mask register contents and gated requests between the top and the gate
// assumes both ends run on the same clock
interface iemr_gate_if;
	logic [7:0] mask;
	logic [5:0] raw_req;
	logic [5:0] gated_req;
	modport top (output mask, output raw_req, input gated_req);
	modport gate (input mask, input raw_req, output gated_req);
endinterface

// ### logic/iemr_gate.sv
// module: combinational gating of the source requests by the mask register
// assumes raw_req is already synchronous to the system clock
module iemr_gate (
	iemr_gate_if.gate gif
);
	import iemr_pkg::*;

	// map a source index to its mask bit position
	function automatic int iemr_src_pos(input int i);
		case (i)
			0: iemr_src_pos = IEMR_X0_POS;
			1: iemr_src_pos = IEMR_T0_POS;
			2: iemr_src_pos = IEMR_X1_POS;
			3: iemr_src_pos = IEMR_T1_POS;
			4: iemr_src_pos = IEMR_UART_POS;
			default: iemr_src_pos = IEMR_T2_POS;
		endcase
	endfunction

	genvar i;
	generate
		for (i = 0; i < IEMR_SRC_N; i = i + 1) begin : g_src
			assign gif.gated_req[i] = gif.raw_req[i] & gif.mask[iemr_src_pos(i)]
				& gif.mask[IEMR_GLOBAL_POS];
		end
	endgenerate
endmodule

// ### logic/iemr_top.sv
// module: interrupt enable mask register on APB, with per-source gating
// assumes peripheral flags arrive on CLK; both external pin requests arrive asynchronously
module iemr_top (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [iemr_pkg::IEMR_ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic EXT_IRQ0_REQ,
	input wire logic EXT_IRQ1_PIN,
	input wire logic TIMER0_OVERFLOW_FLAG,
	input wire logic TIMER1_OVERFLOW_FLAG,
	input wire logic UART_IRQ_REQ,
	input wire logic TIMER2_LOW_OVERFLOW_FLAG,
	input wire logic TIMER2_HIGH_OVERFLOW_FLAG,
	output logic [5:0] IRQ_REQ_GATED,
	output logic GLOBAL_IRQ_ENABLE
);
	import iemr_pkg::*;

	logic [7:0] irq_mask_register_reg;
	logic [1:0] ext0_sync_reg;
	logic [1:0] ext1_sync_reg;
	logic setup_seen_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic [5:0] gated_reg;
	logic global_reg;
	logic access;
	logic complete;
	logic [5:0] raw;

	iemr_gate_if gif ();

	iemr_gate u_gate (
		.gif(gif.gate)
	);

	// first access cycle registers the answer; PREADY rises in the second
	assign access = PSEL & PENABLE & ~setup_seen_reg;
	// writes land only at the completing edge, never while PREADY is still low
	assign complete = PSEL & PENABLE & setup_seen_reg;

	// pins pass two flops before use
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ext0_sync_reg <= 2'h0;
			ext1_sync_reg <= 2'h0;
		end else begin
			ext0_sync_reg <= {ext0_sync_reg[0], EXT_IRQ0_REQ};
			ext1_sync_reg <= {ext1_sync_reg[0], EXT_IRQ1_PIN};
		end
	end

	// either timer2 flag raises the request
	assign raw = {TIMER2_LOW_OVERFLOW_FLAG | TIMER2_HIGH_OVERFLOW_FLAG, UART_IRQ_REQ,
		TIMER1_OVERFLOW_FLAG, ext1_sync_reg[1], TIMER0_OVERFLOW_FLAG, ext0_sync_reg[1]};
	assign gif.raw_req = raw;
	assign gif.mask = irq_mask_register_reg;

	// one-cycle answer: PREADY pulses in the second access cycle
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			setup_seen_reg <= 1'b0;
		end else begin
			setup_seen_reg <= access;
		end
	end

	// mask register, whole byte or one bit at a time
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			irq_mask_register_reg <= IEMR_MASK_RESET;
		end else if (complete && PWRITE) begin
			if (PADDR == IEMR_MASK_OFFSET) begin
				irq_mask_register_reg <= PWDATA[7:0];
			end else if (PADDR == IEMR_BITOP_OFFSET) begin
				irq_mask_register_reg[PWDATA[2:0]] <= PWDATA[IEMR_BITOP_VAL_POS];
			end
		end
	end

	// read mux; unmapped addresses answer with an error
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			prdata_reg <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else if (access) begin
			prdata_reg <= 32'h00000000;
			pslverr_reg <= 1'b0;
			if (PADDR == IEMR_MASK_OFFSET) begin
				if (!PWRITE) begin
					prdata_reg <= {24'h000000, irq_mask_register_reg};
				end
			end else if (PADDR == IEMR_BITOP_OFFSET) begin
				prdata_reg <= 32'h00000000;
			end else if (PADDR == IEMR_STATUS_OFFSET) begin
				if (!PWRITE) begin
					prdata_reg <= {26'h0, gif.gated_req};
				end
			end else begin
				pslverr_reg <= 1'b1;
			end
		end else begin
			pslverr_reg <= 1'b0;
		end
	end

	// registered gated requests and global enable
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			gated_reg <= 6'h00;
			global_reg <= 1'b0;
		end else begin
			gated_reg <= gif.gated_req;
			global_reg <= irq_mask_register_reg[IEMR_GLOBAL_POS];
		end
	end

	assign PRDATA = prdata_reg;
	assign PREADY = setup_seen_reg;
	assign PSLVERR = pslverr_reg;
	assign IRQ_REQ_GATED = gated_reg;
	assign GLOBAL_IRQ_ENABLE = global_reg;
endmodule

// ### test/iemr_sva.sv
// checker: port relations of the interrupt enable mask block
// assumes bind onto iemr_top, one clock
module iemr_sva (
	input logic CLK,
	input logic RST_N,
	input logic PSEL,
	input logic PENABLE,
	input logic [11:0] PADDR,
	input logic PREADY,
	input logic PSLVERR,
	input logic EXT_IRQ1_PIN,
	input logic TIMER0_OVERFLOW_FLAG,
	input logic TIMER1_OVERFLOW_FLAG,
	input logic UART_IRQ_REQ,
	input logic TIMER2_LOW_OVERFLOW_FLAG,
	input logic TIMER2_HIGH_OVERFLOW_FLAG,
	input logic [5:0] IRQ_REQ_GATED,
	input logic GLOBAL_IRQ_ENABLE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// global copy and gated outputs are registered from the same mask cycle
	a_global_off: assert property (!GLOBAL_IRQ_ENABLE |-> IRQ_REQ_GATED == 6'h00)
		else $error("gated while off");
	a_t2_gate: assert property (IRQ_REQ_GATED[5] |-> GLOBAL_IRQ_ENABLE && $past(TIMER2_LOW_OVERFLOW_FLAG | TIMER2_HIGH_OVERFLOW_FLAG))
		else $error("t2 gate");
	a_uart_gate: assert property (IRQ_REQ_GATED[4] |-> GLOBAL_IRQ_ENABLE && $past(UART_IRQ_REQ))
		else $error("uart gate");
	a_ext1_gate: assert property (IRQ_REQ_GATED[2] |-> GLOBAL_IRQ_ENABLE && $past(EXT_IRQ1_PIN, 3))
		else $error("ext1 gate");
	a_t0_gate: assert property (IRQ_REQ_GATED[1] |-> GLOBAL_IRQ_ENABLE && $past(TIMER0_OVERFLOW_FLAG))
		else $error("t0 gate");
	a_addr_map: assert property (PSEL && PENABLE && PREADY |->
		PSLVERR == !(PADDR inside {12'h0A8, 12'h0AC, 12'h0B0})) else $error("map");
	a_t1_gate: assert property (IRQ_REQ_GATED[3] |-> GLOBAL_IRQ_ENABLE && $past(TIMER1_OVERFLOW_FLAG))
		else $error("t1 gate");
	cover property (IRQ_REQ_GATED == 6'h3F);
	cover property (PSLVERR);
	cover property ($rose(GLOBAL_IRQ_ENABLE));
endmodule
bind iemr_top iemr_sva u_iemr_sva (.*);

// ### test/test_interrupt_enable_mask_reg.sv
// bench: mask register over apb, source gating
// assumes iemr_top with its checker bound
module test_interrupt_enable_mask_reg;
	timeunit 1ns;
	timeprecision 100ps;
	import iemr_pkg::*;
	logic CLK, RST_N = 0, psel = 0, pen = 0, pw = 0, rdy, slv, err;
	logic [11:0] pa = 0;
	logic [31:0] pd = 0, prd, rd;
	logic [6:0] src = 0;
	logic [5:0] irq;
	logic gie;
	int n_mismatch = 0, n_compared = 0;
	iemr_top u_iemr_top (.CLK(CLK), .RST_N(RST_N), .PSEL(psel), .PENABLE(pen), .PWRITE(pw),
		.PADDR(pa), .PWDATA(pd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(slv),
		.EXT_IRQ0_REQ(src[0]), .TIMER0_OVERFLOW_FLAG(src[1]), .EXT_IRQ1_PIN(src[2]),
		.TIMER1_OVERFLOW_FLAG(src[3]), .UART_IRQ_REQ(src[4]),
		.TIMER2_LOW_OVERFLOW_FLAG(src[5]), .TIMER2_HIGH_OVERFLOW_FLAG(src[6]),
		.IRQ_REQ_GATED(irq), .GLOBAL_IRQ_ENABLE(gie));
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge CLK);
		psel <= 1;
		pen <= 0;
		pw <= w;
		pa <= a;
		pd <= d;
		@(posedge CLK);
		pen <= 1;
		do @(posedge CLK); while (rdy !== 1'b1);
		rd = prd;
		err = slv;
		psel <= 0;
		pen <= 0;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %0t got %h want %h", $time, g, e);
		end
	endtask
	task t_reg;
		apb(0, IEMR_MASK_OFFSET, 0);
		chk(rd, 0);
		apb(1, IEMR_MASK_OFFSET, 32'h40);
		apb(0, IEMR_MASK_OFFSET, 0);
		chk(rd, 32'h40);
		apb(1, IEMR_MASK_OFFSET, 32'hFFFFFF40);
		apb(0, IEMR_MASK_OFFSET, 0);
		chk(rd, 32'h40);
		$display("t_reg done");
	endtask
	task t_gate;
		src <= 7'h7F;
		apb(1, IEMR_MASK_OFFSET, 32'h7F);
		repeat (4) @(posedge CLK);
		chk(irq, 0);
		chk(gie, 0);
		apb(1, IEMR_BITOP_OFFSET, 32'h107);
		repeat (4) @(posedge CLK);
		chk(irq, 32'h3F);
		chk(gie, 1);
		apb(0, IEMR_STATUS_OFFSET, 0);
		chk(rd, 32'h3F);
		src <= 7'h40;
		repeat (4) @(posedge CLK);
		chk(irq, 32'h20);
		apb(1, IEMR_BITOP_OFFSET, 32'h005);
		repeat (4) @(posedge CLK);
		chk(irq, 0);
		$display("t_gate done");
	endtask
	task t_err;
		apb(1, 12'h0A0, 32'hFF);
		chk(err, 1);
		apb(0, IEMR_MASK_OFFSET, 0);
		chk(rd, 32'hDF);
		chk(err, 0);
		apb(0, IEMR_BITOP_OFFSET, 0);
		chk(rd, 0);
		$display("t_err done");
	endtask
	// mask bits 0 to 5 alone with bit 7 set, then src bits 0 to 5 alone; mask bit i gates output bit i
	task t_src;
		src <= 7'h7F;
		for (int i = 0; i < 6; i++) begin
			apb(1, IEMR_MASK_OFFSET, 32'h80 | (32'h1 << i));
			repeat (4) @(posedge CLK);
			chk(irq, 32'h1 << i);
		end
		apb(1, IEMR_MASK_OFFSET, 32'hFF);
		for (int i = 0; i < 6; i++) begin
			src <= 7'h01 << i;
			repeat (4) @(posedge CLK);
			chk(irq, 32'h1 << i);
		end
		$display("t_src done");
	endtask
	task t_reset;
		src <= 7'h7F;
		RST_N <= 0;
		repeat (2) @(posedge CLK);
		RST_N <= 1;
		@(posedge CLK);
		chk(irq, 0);
		chk(gie, 0);
		apb(0, IEMR_MASK_OFFSET, 0);
		chk(rd, 0);
		$display("t_reset done");
	endtask
	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		CLK = 0;
		forever #12.5 CLK = ~CLK;
	end
	initial begin
		repeat (6) @(posedge CLK);
		RST_N <= 1;
		t_reg;
		t_gate;
		t_err;
		t_src;
		t_reset;
		print_verdict;
	end
	// ample margin over the roughly 160 cycles the tests take
	initial begin
		#50us;
		n_mismatch++;
		print_verdict;
	end
endmodule
